/* rtl/msie_exec.sv */
// Executor for status, bank, pin test, display, key, port, serial and halt instructions.
// Assumes instructions arrive on a valid/ready pair in the sys_clk domain.
//
// What this block does
// RULE1: Set/clear status-one masked bits; test-ones skips when masked status-two bits are 1.
// RULE2: Test-zeros skips when every masked status-two bit is 0.
// RULE3: Clear with field 1100 zeroes both bank flops.
// RULE4: Set with field 0100, 1000 or 1100 loads bank flops from the field.
// RULE5: Interrupt pin test: true form skips on pin low, false form on pin high.
// RULE6: Enable pin test: true form skips on pin high, false form on pin low.
// RULE7: Test-zeros with field 1100 skips when both bank flops are zero.
// RULE8: Bank flop tests skip on 1 (true form) or 0 (false form).
// RULE9: Display write sends decoded pattern or raw memory nibble to the digit.
// RULE10: Key read stores key lines in memory; skip form skips on zero.
// RULE11: Port input copies the selected port into the named register.
// RULE12: Port output writes the named register to the selected port.
// RULE13: Port bits set, clear and all-ones or all-zeros skip tests.
// RULE14: Serial setup loads mode bits 3,1,0; shift-done-true skips on completed byte.
// RULE15: Shift-done-false skips while the shift count is not complete.
// RULE16: Comparator tests skip on above, or on at-or-below.
// RULE17: Opcode 100011 stops the clock on enable low, or halts until restart.
// RULE18: After a taken skip the next instruction is discarded as a no-operation.
`timescale 1ns/100ps
module msie_exec #(
	parameter int MEM_DEPTH = 64,
	parameter int REG_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// Avalon-MM register slave.
	input  wire logic [msie_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest,
	// Instruction stream from program memory.
	input  wire logic                      instr_valid,
	input  wire logic [15:0]               instr_word,
	output logic                           instr_ready,
	output logic                           instr_done,
	output logic                           instr_skipped,
	// Pins, asynchronous to sys_clk.
	input  wire logic                      irq_pin_n,
	input  wire logic                      enable_pin,
	input  wire logic [3:0]                key_lines,
	input  wire logic [15:0]               port_in,
	input  wire logic                      comp_above,
	// Shift clock count from the serial unit, same clock.
	input  wire logic [3:0]                shift_clock_count,
	// Outputs.
	output logic      [15:0]               port_out,
	output logic                           disp_strobe,
	output logic      [3:0]                disp_digit,
	output logic      [7:0]                disp_seg,
	output logic      [3:0]                serial_mode_bits,
	output logic                           cpu_halted,
	output logic                           clock_stopped
);

	// Refuse depths that the fixed address fields cannot reach.
	if (MEM_DEPTH != 64 || REG_DEPTH != 16) begin : g_depth_check
		$error("msie_exec: depths must be 64 and 16");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mask test helpers.
	function automatic logic all_ones(input logic [3:0] v, input logic [3:0] m);
		all_ones = ((v & m) == m);
	endfunction

	function automatic logic all_zeros(input logic [3:0] v, input logic [3:0] m);
		all_zeros = ((v & m) == 4'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: meta stage feeds only the sync stage.
	logic [22:0] pin_meta_reg;
	logic [22:0] pin_sync_reg;
	always_ff @(posedge sys_clk) begin
		pin_meta_reg <= {irq_pin_n, enable_pin, key_lines, port_in, comp_above};
		pin_sync_reg <= pin_meta_reg;
	end

	logic        irq_n_s;
	logic        ce_s;
	logic [3:0]  key_s;
	logic [15:0] port_s;
	logic        cmp_s;
	assign {irq_n_s, ce_s, key_s, port_s, cmp_s} = pin_sync_reg;

	////////////////////////////////////////////////////////////////////////////////
	// State registers.
	logic [3:0]          status1_reg, status1_next;
	logic [3:0]          status2_reg, status2_next;
	logic [1:0]          bank_reg, bank_next;
	logic [15:0]         port_out_reg, port_out_next;
	logic [3:0]          serial_reg, serial_next;
	logic [3:0]          restart_reg, restart_next;
	msie_pkg::msie_run_t run_reg, run_next;
	logic                skip_pend_reg, skip_pend_next;
	logic                halted_reg, halted_next;
	logic                stopped_reg, stopped_next;
	logic [3:0]          status2_next_bus;
	logic                ready_reg, ready_next;
	logic                done_reg, done_next;
	logic                skipped_reg, skipped_next;
	logic                dstrobe_reg, dstrobe_next;
	logic [3:0]          ddigit_reg, ddigit_next;
	logic [7:0]          dseg_reg, dseg_next;
	logic                direct_reg, direct_next;
	logic [5:0]          maddr_reg, maddr_next;
	logic                wait_reg, wait_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic [3:0]          data_mem [MEM_DEPTH];
	logic [3:0]          gen_reg [REG_DEPTH];
	logic                mem_we, gen_we;
	logic [5:0]          mem_wa;
	logic [3:0]          mem_wd, gen_wa, gen_wd;

	// Instruction fields.
	logic [5:0] op;
	logic [1:0] hi;
	logic [3:0] mid, low;
	logic       taken, exec, hit, bus_req, bus_ack;
	assign op      = instr_word[15:msie_pkg::OP_LSB];
	assign hi      = instr_word[msie_pkg::OP_LSB-1:msie_pkg::HI_LSB];
	assign mid     = instr_word[msie_pkg::HI_LSB-1:msie_pkg::MID_LSB];
	assign low     = instr_word[msie_pkg::MID_LSB-1:msie_pkg::LOW_LSB];
	assign taken   = instr_valid && ready_reg;
	assign exec    = taken && !skip_pend_reg;
	assign bus_req = avs_read || avs_write;
	assign bus_ack = bus_req && !wait_reg;

	// Segment decoder sees the memory nibble addressed by the display write.
	msie_seg_if seg_bus ();
	assign seg_bus.nibble = data_mem[{hi, low}];
	assign seg_bus.direct = direct_reg;
	msie_seg_dec u_seg (
		.seg (seg_bus.dec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Instruction execution and run state.
	always_comb begin
		status1_next  = status1_reg;
		status2_next  = status2_reg;
		bank_next     = bank_reg;
		port_out_next = port_out_reg;
		serial_next   = serial_reg;
		restart_next  = restart_reg;
		run_next      = run_reg;
		dstrobe_next  = 1'b0;
		ddigit_next   = ddigit_reg;
		dseg_next     = dseg_reg;
		mem_we        = 1'b0;
		mem_wa        = {hi, mid};
		mem_wd        = key_s;
		gen_we        = 1'b0;
		gen_wa        = low;
		gen_wd        = port_s[{hi, 2'b00} +: 4];
		hit           = 1'b0;
		if (exec) begin
			case (op)
				msie_pkg::OP_SET: begin
					if (mid == msie_pkg::F_STAT) status1_next = status1_reg | low;         // RULE1
					else if (mid == msie_pkg::F_NONE) port_out_next[{hi, 2'b00} +: 4] =
						port_out_reg[{hi, 2'b00} +: 4] | low;                               // RULE13
					else if (mid[1:0] == 2'b00) bank_next = mid[3:2];                      // RULE4
				end
				msie_pkg::OP_CLR: begin
					if (mid == msie_pkg::F_STAT) status1_next = status1_reg & ~low;        // RULE1
					else if (mid == msie_pkg::F_NONE) port_out_next[{hi, 2'b00} +: 4] =
						port_out_reg[{hi, 2'b00} +: 4] & ~low;                              // RULE13
					else if (mid == msie_pkg::F_BOTH) bank_next = 2'b00;                   // RULE3
				end
				msie_pkg::OP_TEST1: begin
					case (mid)
						msie_pkg::F_STAT: hit = all_ones(status2_reg, low);               // RULE1
						msie_pkg::F_NONE: hit = all_ones(port_s[{hi, 2'b00} +: 4], low);  // RULE13
						msie_pkg::F_IRQ:  hit = !irq_n_s;                                 // RULE5
						msie_pkg::F_CE:   hit = ce_s;                                     // RULE6
						msie_pkg::F_BLO:  hit = bank_reg[0];                              // RULE8
						msie_pkg::F_BHI:  hit = bank_reg[1];                              // RULE8
						default:          hit = 1'b0;
					endcase
				end
				msie_pkg::OP_TEST0: begin
					case (mid)
						msie_pkg::F_STAT: hit = all_zeros(status2_reg, low);              // RULE2
						msie_pkg::F_NONE: hit = all_zeros(port_s[{hi, 2'b00} +: 4], low); // RULE13
						msie_pkg::F_IRQ:  hit = irq_n_s;                                  // RULE5
						msie_pkg::F_CE:   hit = !ce_s;                                    // RULE6
						msie_pkg::F_BLO:  hit = !bank_reg[0];                             // RULE8
						msie_pkg::F_BHI:  hit = !bank_reg[1];                             // RULE8
						msie_pkg::F_BOTH: hit = (bank_reg == 2'b00);                      // RULE7
						default:          hit = 1'b0;
					endcase
				end
				msie_pkg::OP_KEY: begin
					mem_we = 1'b1;                                                       // RULE10
					hit    = (low != msie_pkg::F_NONE) && (key_s == 4'h0);               // RULE10
				end
				msie_pkg::OP_PORT_IN: gen_we = 1'b1;                                     // RULE11
				msie_pkg::OP_PORT_OUT: port_out_next[{hi, 2'b00} +: 4] = gen_reg[low];  // RULE12
				msie_pkg::OP_DISP: begin
					dstrobe_next = 1'b1;                                                 // RULE9
					ddigit_next  = mid;
					dseg_next    = seg_bus.pattern;                                      // RULE9
				end
				msie_pkg::OP_MISC: begin
					if (hi == msie_pkg::HI_00 && mid == msie_pkg::F_IRQ)
						serial_next = (serial_reg & ~msie_pkg::SER_LOAD_MASK) |
							(low & msie_pkg::SER_LOAD_MASK);                                // RULE14
				end
				msie_pkg::OP_STEST: begin
					if (mid == msie_pkg::F_IRQ && hi == msie_pkg::HI_10)
						hit = (shift_clock_count == msie_pkg::SHIFT_DONE_COUNT);           // RULE14
					else if (mid == msie_pkg::F_IRQ && hi == msie_pkg::HI_00)
						hit = (shift_clock_count != msie_pkg::SHIFT_DONE_COUNT);           // RULE15
					else if (mid == msie_pkg::F_NONE && hi == msie_pkg::HI_00)
						hit = cmp_s;                                                      // RULE16
					else if (mid == msie_pkg::F_NONE && hi == msie_pkg::HI_10)
						hit = !cmp_s;                                                     // RULE16
				end
				msie_pkg::OP_HALT: begin
					if (mid == msie_pkg::F_STOP && low == msie_pkg::F_STOP) begin
						if (!ce_s) run_next = msie_pkg::MSIE_STOP;                        // RULE17
					end else begin
						run_next     = msie_pkg::MSIE_HALT;                               // RULE17
						restart_next = low;
					end
				end
				default: hit = 1'b0;
			endcase
		end
		// Wake-up: a stopped clock restarts on enable high, a halt on its chosen condition.
		case (run_reg)
			msie_pkg::MSIE_HALT: begin
				if ((restart_reg[msie_pkg::RS_IRQ] && !irq_n_s) || (restart_reg[msie_pkg::RS_CE] && ce_s) ||
					(restart_reg[msie_pkg::RS_KEY] && key_s != 4'h0) ||
					(restart_reg[msie_pkg::RS_CMP] && cmp_s)) run_next = msie_pkg::MSIE_RUN;  // RULE17
			end
			msie_pkg::MSIE_STOP: if (ce_s) run_next = msie_pkg::MSIE_RUN;                   // RULE17
			default: ;
		endcase
		// A discarded instruction clears the pending skip; an executed instruction loads it from its test result.
		skip_pend_next = exec ? hit : (taken ? 1'b0 : skip_pend_reg);                   // RULE18
		skipped_next   = taken && skip_pend_reg;                                         // RULE18
		done_next      = exec;
		ready_next     = (run_next == msie_pkg::MSIE_RUN);
		halted_next    = (run_next == msie_pkg::MSIE_HALT);
		stopped_next   = (run_next == msie_pkg::MSIE_STOP);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status1_reg   <= msie_pkg::RST_NIB;
			status2_reg   <= msie_pkg::RST_NIB;
			bank_reg      <= 2'b00;
			port_out_reg  <= 16'h0000;
			serial_reg    <= msie_pkg::RST_NIB;
			restart_reg   <= msie_pkg::RST_NIB;
			run_reg       <= msie_pkg::MSIE_RUN;
			skip_pend_reg <= 1'b0;
			skipped_reg   <= 1'b0;
			done_reg      <= 1'b0;
			ready_reg     <= 1'b0;
			dstrobe_reg   <= 1'b0;
			ddigit_reg    <= msie_pkg::RST_NIB;
			dseg_reg      <= msie_pkg::RST_BYTE;
			halted_reg    <= 1'b0;
			stopped_reg   <= 1'b0;
		end else begin
			status1_reg   <= status1_next;
			status2_reg   <= status2_next_bus;
			bank_reg      <= bank_next;
			port_out_reg  <= port_out_next;
			serial_reg    <= serial_next;
			restart_reg   <= restart_next;
			run_reg       <= run_next;
			skip_pend_reg <= skip_pend_next;
			skipped_reg   <= skipped_next;
			done_reg      <= done_next;
			ready_reg     <= ready_next;
			dstrobe_reg   <= dstrobe_next;
			ddigit_reg    <= ddigit_next;
			dseg_reg      <= dseg_next;
			halted_reg    <= halted_next;
			stopped_reg   <= stopped_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle per access, instruction memory writes win.
	logic [31:0] state_word;
	logic        bus_mem_we;
	assign state_word = {12'h000, serial_reg, 2'b00, (run_reg == msie_pkg::MSIE_STOP),
		(run_reg == msie_pkg::MSIE_HALT), 2'b00, bank_reg, status2_reg, status1_reg};

	always_comb begin
		wait_next        = !(bus_req && wait_reg);
		rdata_next       = rdata_reg;
		direct_next      = direct_reg;
		maddr_next       = maddr_reg;
		status2_next_bus = status2_next;
		bus_mem_we       = 1'b0;
		if (bus_req && wait_reg && avs_read) begin
			case (avs_address)
				msie_pkg::REG_CTRL:  rdata_next = {31'h0000_0000, direct_reg};
				msie_pkg::REG_STATE: rdata_next = state_word;
				msie_pkg::REG_STAT2: rdata_next = {28'h000_0000, status2_reg};
				msie_pkg::REG_MADDR: rdata_next = {26'h000_0000, maddr_reg};
				msie_pkg::REG_MDATA: rdata_next = {28'h000_0000, data_mem[maddr_reg]};
				default:             rdata_next = msie_pkg::RST_WORD;
			endcase
		end
		if (bus_ack && avs_write) begin
			case (avs_address)
				msie_pkg::REG_CTRL:  direct_next = avs_writedata[msie_pkg::CTRL_DIRECT];
				msie_pkg::REG_STAT2: status2_next_bus = avs_writedata[3:0];
				msie_pkg::REG_MADDR: maddr_next = avs_writedata[5:0];
				msie_pkg::REG_MDATA: bus_mem_we = !mem_we;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wait_reg   <= 1'b1;
			rdata_reg  <= msie_pkg::RST_WORD;
			direct_reg <= 1'b0;
			maddr_reg  <= 6'h00;
		end else begin
			wait_reg   <= wait_next;
			rdata_reg  <= rdata_next;
			direct_reg <= direct_next;
			maddr_reg  <= maddr_next;
		end
	end

	// Data memory and general registers.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < MEM_DEPTH; i++) data_mem[i] <= msie_pkg::RST_NIB;
			for (int j = 0; j < REG_DEPTH; j++) gen_reg[j] <= msie_pkg::RST_NIB;
		end else begin
			if (mem_we) data_mem[mem_wa] <= mem_wd;                                         // RULE10
			else if (bus_mem_we) data_mem[maddr_reg] <= avs_writedata[3:0];
			if (gen_we) gen_reg[gen_wa] <= gen_wd;                                          // RULE11
		end
	end

	// Outputs straight from flops.
	assign avs_readdata     = rdata_reg;
	assign avs_waitrequest  = wait_reg;
	assign instr_ready      = ready_reg;
	assign instr_done       = done_reg;
	assign instr_skipped    = skipped_reg;
	assign port_out         = port_out_reg;
	assign disp_strobe      = dstrobe_reg;
	assign disp_digit       = ddigit_reg;
	assign disp_seg         = dseg_reg;
	assign serial_mode_bits = serial_reg;
	assign cpu_halted       = halted_reg;
	assign clock_stopped    = stopped_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks and coverage.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_skip_discards: assert property (taken && skip_pend_reg |=> instr_skipped && !instr_done && !skip_pend_reg) // RULE18
		else $error("skipped instruction was executed");
	a_stat1_set: assert property (exec && op == msie_pkg::OP_SET && mid == msie_pkg::F_STAT |=> // RULE1
		(status1_reg & $past(low)) == $past(low)) else $error("status one bits not set");
	a_stat2_zero: assert property (exec && op == msie_pkg::OP_TEST0 && mid == msie_pkg::F_STAT && // RULE2
		(status2_reg & low) == 4'h0 |=> skip_pend_reg) else $error("status two zero test missed skip");
	a_bank_first: assert property (exec && op == msie_pkg::OP_CLR && mid == msie_pkg::F_BOTH |=> // RULE3
		bank_reg == 2'b00) else $error("first bank not selected");
	a_bank_load: assert property (exec && op == msie_pkg::OP_SET && mid == msie_pkg::F_BHI |=> // RULE4
		bank_reg == 2'b10) else $error("bank flops not loaded");
	a_irq_true: assert property (exec && op == msie_pkg::OP_TEST1 && mid == msie_pkg::F_IRQ |=> // RULE5
		skip_pend_reg == !$past(irq_n_s)) else $error("interrupt pin test wrong");
	a_ce_false: assert property (exec && op == msie_pkg::OP_TEST0 && mid == msie_pkg::F_CE |=> // RULE6
		skip_pend_reg == !$past(ce_s)) else $error("enable pin test wrong");
	a_key_zero: assert property (exec && op == msie_pkg::OP_KEY && low != 4'h0 && key_s == 4'h0 // RULE10
		|=> skip_pend_reg && instr_done)
		else $error("key skip missed");
	a_port_write: assert property (exec && op == msie_pkg::OP_PORT_OUT |=> // RULE12
		port_out[{$past(hi), 2'b00} +: 4] == $past(gen_reg[low])) else $error("port output wrong");
	a_serial_keep: assert property (exec && op == msie_pkg::OP_MISC && hi == msie_pkg::HI_00 && // RULE14
		mid == msie_pkg::F_IRQ |=> serial_mode_bits[2] == $past(serial_reg[2]) &&
		(serial_mode_bits & msie_pkg::SER_LOAD_MASK) == ($past(low) & msie_pkg::SER_LOAD_MASK))
		else $error("serial mode load wrong");
	a_halt_stall: assert property (exec && op == msie_pkg::OP_HALT && mid != msie_pkg::F_STOP |=> // RULE17
		cpu_halted && !instr_ready) else $error("halt did not stall");
	a_wait_one: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("wait request not one cycle");

	c_skip: cover property (taken && skip_pend_reg);
	c_halt_wake: cover property (cpu_halted ##1 !cpu_halted);
	c_disp: cover property (disp_strobe && direct_reg);
	c_stop: cover property (clock_stopped);

endmodule

/* rtl/msie_pkg.sv */
// Package for the status, bank and I/O instruction execution slice.
// Assumes a 16-bit instruction word: opcode[15:10], high[9:8], middle[7:4], low[3:0].
package msie_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction word layout.
	localparam int INSTR_W  = 16;
	localparam int OP_LSB   = 10;
	localparam int HI_LSB   = 8;
	localparam int MID_LSB  = 4;
	localparam int LOW_LSB  = 0;

	// Opcodes handled by this slice.
	localparam logic [5:0] OP_MISC     = 6'h00;
	localparam logic [5:0] OP_SET      = 6'h01;
	localparam logic [5:0] OP_CLR      = 6'h03;
	localparam logic [5:0] OP_TEST0    = 6'h08;
	localparam logic [5:0] OP_TEST1    = 6'h09;
	localparam logic [5:0] OP_KEY      = 6'h10;
	localparam logic [5:0] OP_PORT_OUT = 6'h22;
	localparam logic [5:0] OP_HALT     = 6'h23;
	localparam logic [5:0] OP_DISP     = 6'h27;
	localparam logic [5:0] OP_STEST    = 6'h28;
	localparam logic [5:0] OP_PORT_IN  = 6'h32;

	// Middle-field selectors.
	localparam logic [3:0] F_NONE = 4'h0;
	localparam logic [3:0] F_IRQ  = 4'h1;
	localparam logic [3:0] F_CE   = 4'h2;
	localparam logic [3:0] F_BLO  = 4'h4;
	localparam logic [3:0] F_BHI  = 4'h8;
	localparam logic [3:0] F_BOTH = 4'hC;
	localparam logic [3:0] F_STOP = 4'hE;
	localparam logic [3:0] F_STAT = 4'hF;

	// High-field selectors.
	localparam logic [1:0] HI_00 = 2'h0;
	localparam logic [1:0] HI_10 = 2'h2;

	// Serial mode bits loaded by the setup instruction (bits 3, 1 and 0).
	localparam logic [3:0] SER_LOAD_MASK    = 4'hB;
	localparam logic [3:0] SHIFT_DONE_COUNT = 4'h8;

	// Restart condition bits of the halt operand.
	localparam int RS_IRQ = 0;
	localparam int RS_CE  = 1;
	localparam int RS_KEY = 2;
	localparam int RS_CMP = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, word index on avs_address (byte offset is four times it).
	localparam int         ADDR_W    = 3;
	localparam logic [2:0] REG_CTRL  = 3'h0;
	localparam logic [2:0] REG_STATE = 3'h1;
	localparam logic [2:0] REG_STAT2 = 3'h2;
	localparam logic [2:0] REG_MADDR = 3'h3;
	localparam logic [2:0] REG_MDATA = 3'h4;

	// Field positions.
	localparam int CTRL_DIRECT = 0;
	localparam int ST_S1_LSB   = 0;
	localparam int ST_S2_LSB   = 4;
	localparam int ST_BANK_LSB = 8;
	localparam int ST_HALT     = 12;
	localparam int ST_STOP     = 13;
	localparam int ST_SER_LSB  = 16;

	// Reset values.
	localparam logic [3:0]  RST_NIB  = 4'h0;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Run state, Gray coded along run, halt, stop.
	typedef enum logic [1:0] {
		MSIE_RUN  = 2'b00,
		MSIE_HALT = 2'b01,
		MSIE_STOP = 2'b11
	} msie_run_t;

endpackage

/* rtl/msie_seg_if.sv */
// Carrier between the executor and its segment decoder.
// Assumes both ends run combinationally in one clock domain.
`timescale 1ns/100ps
interface msie_seg_if;
	logic [3:0] nibble;
	logic       direct;
	logic [7:0] pattern;
	modport dec  (input nibble, input direct, output pattern);
	modport user (output nibble, output direct, input pattern);
endinterface

/* rtl/msie_seg_dec.sv */
// Segment decoder: nibble to seven-segment pattern, or raw nibble pass.
// Assumes a pure combinational path; the caller registers the result.
`timescale 1ns/100ps
module msie_seg_dec (
	// Decoder port.
	msie_seg_if.dec seg
);

	// Pattern bits are gfedcba, active high; direct mode passes the nibble.
	always_comb begin
		if (seg.direct) begin
			seg.pattern = {4'h0, seg.nibble};
		end else begin
			case (seg.nibble)
				4'h0: seg.pattern = 8'h3F;
				4'h1: seg.pattern = 8'h06;
				4'h2: seg.pattern = 8'h5B;
				4'h3: seg.pattern = 8'h4F;
				4'h4: seg.pattern = 8'h66;
				4'h5: seg.pattern = 8'h6D;
				4'h6: seg.pattern = 8'h7D;
				4'h7: seg.pattern = 8'h07;
				4'h8: seg.pattern = 8'h7F;
				4'h9: seg.pattern = 8'h6F;
				4'hA: seg.pattern = 8'h77;
				4'hB: seg.pattern = 8'h7C;
				4'hC: seg.pattern = 8'h39;
				4'hD: seg.pattern = 8'h5E;
				4'hE: seg.pattern = 8'h79;
				default: seg.pattern = 8'h71;
			endcase
		end
	end

endmodule

/* sim/msie_prog_model.sv */
// Program memory stand-in that offers one instruction word on valid and ready.
// Assumes the bench pulses req for one cycle together with the word to offer.
`timescale 1ns/100ps
module msie_prog_model (
	// Clock and bench request.
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        req,
	input  wire logic [15:0] word_in,
	// Instruction stream.
	input  wire logic        instr_ready,
	output logic             instr_valid,
	output logic      [15:0] instr_word
);
	// Hold the word until taken, then invert it so a stale word never looks valid.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			instr_valid <= 1'b0;
			instr_word  <= 16'h0000;
		end else if (instr_valid && instr_ready) begin
			instr_valid <= 1'b0;
			instr_word  <= ~instr_word;
		end else if (req) begin
			instr_valid <= 1'b1;
			instr_word  <= word_in;
		end
	end
endmodule

/* sim/msie_exec_tb.sv */
// Self-checking bench for the status, bank and I/O executor.
// Assumes the program model feeds words; the bench drives pins and the register bus.
`timescale 1ns/100ps
module msie_exec_tb;
	logic	sys_clk = 0, sys_rst = 1, req = 0, irq_pin_n = 1, enable_pin = 1, comp_above = 0;
	logic	avs_read = 0, avs_write = 0, instr_valid, instr_ready, instr_done, instr_skipped;
	logic	disp_strobe, cpu_halted, clock_stopped, avs_waitrequest;
	logic [2:0]	avs_address = 3'h0;
	logic [3:0]	key_lines = 4'h0, shift_clock_count = 4'h0, disp_digit, serial_mode_bits;
	logic [7:0]	disp_seg;
	logic [15:0]	word_in = 16'h0000, port_in = 16'h0C00, instr_word, port_out;
	logic [31:0]	avs_writedata = 32'h0, avs_readdata, q;
	int	bad_count = 0, comparisons = 0, cyc = 0, n;
	// Bit 16 is the expected skip flag, the rest the instruction word.
	logic [16:0]	rows [0:32] = '{17'h004F5, 17'h00440, 17'h02440, 17'h1040F, 17'h02040, 17'h0050F,
		17'h02480, 17'h02080, 17'h10000, 17'h00CC0, 17'h020C0, 17'h10000, 17'h02010, 17'h10000,
		17'h02420, 17'h10000, 17'h020FF, 17'h10000, 17'h0A010, 17'h10000, 17'h0A000, 17'h0A200,
		17'h10000, 17'h04011, 17'h10000, 17'h0001F, 17'h0CA05, 17'h08B05, 17'h09C30, 17'h02410,
		17'h0210F, 17'h10000, 17'h00D03};
	msie_exec msie_exec_i (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .instr_valid, .instr_word, .instr_ready, .instr_done,
		.instr_skipped, .irq_pin_n, .enable_pin, .key_lines, .port_in, .comp_above, .shift_clock_count,
		.port_out, .disp_strobe, .disp_digit, .disp_seg, .serial_mode_bits, .cpu_halted, .clock_stopped);
	msie_prog_model msie_prog_model_i (.sys_clk, .sys_rst, .req, .word_in, .instr_ready, .instr_valid,
		.instr_word);
	////////////////////////////////////////////////////////////////////////////////
	// Clock and a cycle ceiling that cuts a hang short.
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Offer one word and compare the skip flag in the answer cycle.
	task automatic ex(input logic [15:0] w, input logic sk);
		int k;
		k = 0;
		@(posedge sys_clk);
		req <= 1'b1;
		word_in <= w;
		@(posedge sys_clk);
		req <= 1'b0;
		do @(posedge sys_clk); while (!(instr_done | instr_skipped) && ++k < 20);
		chk(instr_done | instr_skipped, 1'b1);
		chk(instr_skipped, sk);
	endtask
	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++k < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset, the table of rows, then bus, halt and clock-stop cases.
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) ex(rows[i][15:0], rows[i][16]);
		chk(port_out, 16'hC0C0);
		chk(serial_mode_bits, 4'hB);
		chk({disp_digit, disp_seg}, 12'h33F);
		$display("table rows done");
		bus(1'b0, 3'h1, 32'h0);
		chk(q, 32'h000B0005);
		bus(1'b1, 3'h2, 32'hA);
		bus(1'b0, 3'h7, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 3'h2, 32'h0);
		chk(q, 32'hA);
		key_lines <= 4'h6;
		ex(16'h4021, 1'b0);
		bus(1'b1, 3'h0, 32'h1);
		ex(16'h9C52, 1'b0);
		chk({disp_strobe, disp_digit, disp_seg}, 13'h1506);
		ex(16'h24FA, 1'b0);
		ex(16'h0000, 1'b1);
		shift_clock_count <= 4'h8;
		ex(16'hA210, 1'b0);
		ex(16'h0000, 1'b1);
		$display("bus and skip cases done");
		ex(16'h8C01, 1'b0);
		chk(cpu_halted, 1'b1);
		chk(instr_ready, 1'b0);
		irq_pin_n <= 1'b0;
		n = 0;
		do @(posedge sys_clk); while (cpu_halted && ++n < 10);
		chk(cpu_halted, 1'b0);
		ex(16'h2410, 1'b0);
		ex(16'h0000, 1'b1);
		enable_pin <= 1'b0;
		repeat (3) @(posedge sys_clk);
		ex(16'h8CEE, 1'b0);
		chk(clock_stopped, 1'b1);
		enable_pin <= 1'b1;
		n = 0;
		do @(posedge sys_clk); while (clock_stopped && ++n < 10);
		chk(clock_stopped, 1'b0);
		$display("halt and stop cases done");
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		chk({port_out, serial_mode_bits, instr_ready, avs_waitrequest}, 22'h000001);
		$display("mid-run reset case done");
		stop_test();
	end
endmodule
